/* File: estx_pkg.sv */
// Constants, encodings and carrier types shared by the extended-instruction executor.
// Assumes one 200 MHz system clock and synchronous program and data memories on that clock.
package estx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DW = 8;
  localparam int unsigned PM_DW = 16;
  localparam int unsigned PM_AW = 12;
  localparam int unsigned DM_AW = 9;
  localparam int unsigned PAGE_HI_W = 4;
  localparam int unsigned OP_W = 4;
  localparam int unsigned BIT_W = 3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned OP_LSB = 0;
  localparam int unsigned BIT_LSB = 4;
  localparam int unsigned ADDR_LSB = 16;
  localparam int unsigned STS_Z = 0;
  localparam int unsigned STS_BUSY = 1;
  localparam int unsigned STS_SKIP = 2;

  // ----------------------------------------------------------------
  // Register byte offsets on APB
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_TPTR_LO = 8'h08;
  localparam logic [7:0] REG_TPTR_HI = 8'h0c;
  localparam logic [7:0] REG_TLATCH = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_PC = 8'h18;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [PAGE_HI_W-1:0] LAST_PAGE = 4'hf;
  localparam logic [DW-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DW-1:0] ONE_BYTE = 8'h01;
  localparam logic [PM_AW-1:0] PC_RST = 12'h000;
  localparam logic [PM_AW-1:0] PC_STEP = 12'h001;
  localparam logic [PM_AW-1:0] PC_SKIP_STEP = 12'h002;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    OP_NOP = 4'h0,
    OP_SZ = 4'h1,
    OP_SZA = 4'h2,
    OP_SZB = 4'h3,
    OP_TABRD = 4'h4,
    OP_TABRDL = 4'h5,
    OP_ITABRD = 4'h6,
    OP_ITABRDL = 4'h7,
    OP_XOR = 4'h8,
    OP_XORM = 4'h9
  } estx_op_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RDWAIT, ST_EXEC, ST_TAB, ST_PMWAIT, ST_TABWB, ST_DUMMY} estx_st_t;

  typedef struct packed {
    logic re;
    logic we;
    logic [DM_AW-1:0] addr;
    logic [DW-1:0] wdata;
  } estx_dm_req_t;

  typedef struct packed {
    logic re;
    logic [PM_AW-1:0] addr;
  } estx_pm_req_t;

  typedef struct packed {
    logic skip;
    logic acc_ld;
    logic [DW-1:0] acc_val;
    logic mem_wr;
    logic [DW-1:0] mem_val;
    logic z_wr;
    logic z_val;
  } estx_exec_t;

  typedef struct packed {
    estx_st_t st;
    estx_op_t op;
    logic [BIT_W-1:0] bit_sel;
    logic [DM_AW-1:0] addr;
    logic [DW-1:0] acc;
    logic [DW-1:0] tptr_lo;
    logic [DW-1:0] tptr_hi;
    logic [DW-1:0] tlatch;
    logic z;
    logic skipped;
    logic done;
    logic [PM_AW-1:0] pc;
    estx_dm_req_t dm_req;
    estx_pm_req_t pm_req;
    logic [31:0] prdata;
  } estx_state_t;

endpackage

/* File: estx_exec_unit.sv */
// Combinational evaluation of the byte-operand instructions: skip tests, move and XOR.
// Assumes the caller presents the data byte read from memory and applies the result one edge later.
`timescale 1ns/1ps
module estx_exec_unit (
  input wire estx_pkg::estx_op_t op,
  input wire logic [estx_pkg::BIT_W-1:0] bit_sel,
  input wire logic [estx_pkg::DW-1:0] acc,
  input wire logic [estx_pkg::DW-1:0] mem,
  output estx_pkg::estx_exec_t res
);

  // ----------------------------------------------------------------
  // Bit selection
  // ----------------------------------------------------------------
  logic [estx_pkg::DW-1:0] bit_hit;
  logic bit_zero;
  logic [estx_pkg::DW-1:0] xor_val;

  for (genvar i = 0; i < estx_pkg::DW; i++)
  begin : g_bit
    assign bit_hit[i] = (bit_sel == estx_pkg::BIT_W'(i)) & ~mem[i];
  end

  assign bit_zero = |bit_hit;
  assign xor_val = acc ^ mem;

  // ----------------------------------------------------------------
  // Result
  // ----------------------------------------------------------------
  always_comb
  begin
    res = '0;
    case (op)
      estx_pkg::OP_SZ:
      begin
        res.skip = (mem == estx_pkg::ZERO_BYTE);
      end
      estx_pkg::OP_SZA:
      begin
        res.skip = (mem == estx_pkg::ZERO_BYTE);
        res.acc_ld = 1'b1;
        res.acc_val = mem;
      end
      estx_pkg::OP_SZB:
      begin
        res.skip = bit_zero;
      end
      estx_pkg::OP_XOR:
      begin
        res.acc_ld = 1'b1;
        res.acc_val = xor_val;
        res.z_wr = 1'b1;
        res.z_val = (xor_val == estx_pkg::ZERO_BYTE);
      end
      estx_pkg::OP_XORM:
      begin
        res.mem_wr = 1'b1;
        res.mem_val = xor_val;
        res.z_wr = 1'b1;
        res.z_val = (xor_val == estx_pkg::ZERO_BYTE);
      end
      default:
      begin
        res = '0;
      end
    endcase
  end

endmodule

/* File: estx_exec_top.sv */
// Executor for extended skip, table-read and XOR instructions, issued and observed over APB.
// Assumes program and data memories on sys_clk that return read data one cycle after a request.
//
// Summary of operation
// - Byte skip-if-zero skips the next instruction when the byte is zero; no flag changes.
// - A taken skip adds one dummy cycle, so the instruction takes three cycles.
// - Skip-if-zero-with-move copies the byte to accumulator, skips if zero, no flags.
// - Bit skip-if-zero skips when the selected bit is zero; flags stay unchanged.
// - Current-page table read: low byte to memory, high byte to table-high latch.
// - Last-page table read uses the last page with table pointer low byte.
// - Incrementing read bumps pointer low, then reads at pointer high and low.
// - Incrementing last-page read bumps pointer low first, then reads last page.
// - XOR to accumulator stores accumulator XOR byte there, updating only zero flag.
// - XOR to memory writes accumulator XOR byte back, updating only zero flag.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module estx_exec_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output estx_pkg::estx_dm_req_t dm_req,
  input wire logic [estx_pkg::DW-1:0] dm_rdata,
  output estx_pkg::estx_pm_req_t pm_req,
  input wire logic [estx_pkg::PM_DW-1:0] pm_rdata,
  output logic skip_dummy,
  output logic instr_done
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  estx_pkg::estx_state_t q;
  estx_pkg::estx_state_t d;
  estx_pkg::estx_exec_t ex;
  logic busy;
  logic access;
  logic wr_ok;
  logic mapped;
  logic err;
  logic [31:0] rd_mux;
  logic [estx_pkg::DW-1:0] tptr_lo_inc;

  estx_exec_unit u_exec (
    .op(q.op),
    .bit_sel(q.bit_sel),
    .acc(q.acc),
    .mem(dm_rdata),
    .res(ex)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign busy = (q.st != estx_pkg::ST_IDLE);
  assign access = psel & penable & ce;
  assign tptr_lo_inc = q.tptr_lo + estx_pkg::ONE_BYTE;

  // Writes are refused while an instruction runs so software cannot race the sequencer.
  always_comb
  begin
    mapped = 1'b1;
    err = 1'b0;
    case (paddr)
      estx_pkg::REG_INSTR, estx_pkg::REG_ACC, estx_pkg::REG_TPTR_LO, estx_pkg::REG_TPTR_HI, estx_pkg::REG_PC:
      begin
        err = pwrite & busy;
      end
      estx_pkg::REG_TLATCH, estx_pkg::REG_STATUS:
      begin
        err = pwrite;
      end
      default:
      begin
        mapped = 1'b0;
        err = 1'b1;
      end
    endcase
  end

  assign wr_ok = access & pwrite & mapped & ~err;
  assign pready = access;
  assign pslverr = access & err;
  assign prdata = q.prdata;
  assign dm_req = q.dm_req;
  assign pm_req = q.pm_req;
  assign skip_dummy = (q.st == estx_pkg::ST_DUMMY);
  assign instr_done = q.done;

  always_comb
  begin
    rd_mux = '0;
    case (paddr)
      estx_pkg::REG_INSTR:
      begin
        rd_mux[estx_pkg::OP_LSB +: estx_pkg::OP_W] = q.op;
        rd_mux[estx_pkg::BIT_LSB +: estx_pkg::BIT_W] = q.bit_sel;
        rd_mux[estx_pkg::ADDR_LSB +: estx_pkg::DM_AW] = q.addr;
      end
      estx_pkg::REG_ACC: rd_mux[estx_pkg::DW-1:0] = q.acc;
      estx_pkg::REG_TPTR_LO: rd_mux[estx_pkg::DW-1:0] = q.tptr_lo;
      estx_pkg::REG_TPTR_HI: rd_mux[estx_pkg::DW-1:0] = q.tptr_hi;
      estx_pkg::REG_TLATCH: rd_mux[estx_pkg::DW-1:0] = q.tlatch;
      estx_pkg::REG_PC: rd_mux[estx_pkg::PM_AW-1:0] = q.pc;
      estx_pkg::REG_STATUS:
      begin
        rd_mux[estx_pkg::STS_Z] = q.z;
        rd_mux[estx_pkg::STS_BUSY] = busy;
        rd_mux[estx_pkg::STS_SKIP] = q.skipped;
      end
      default: rd_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.dm_req = '0;
    d.pm_req = '0;
    // Read data is captured in the setup cycle so it can leave a flip-flop in the access cycle.
    if (psel && !penable)
    begin
      d.prdata = rd_mux;
    end
    if (wr_ok)
    begin
      case (paddr)
        estx_pkg::REG_ACC: d.acc = pwdata[estx_pkg::DW-1:0];
        estx_pkg::REG_TPTR_LO: d.tptr_lo = pwdata[estx_pkg::DW-1:0];
        estx_pkg::REG_TPTR_HI: d.tptr_hi = pwdata[estx_pkg::DW-1:0];
        estx_pkg::REG_PC: d.pc = pwdata[estx_pkg::PM_AW-1:0];
        default:
        begin
        end
      endcase
    end
    case (q.st)
      estx_pkg::ST_IDLE:
      begin
        if (wr_ok && paddr == estx_pkg::REG_INSTR)
        begin
          d.op = estx_pkg::estx_op_t'(pwdata[estx_pkg::OP_LSB +: estx_pkg::OP_W]);
          d.bit_sel = pwdata[estx_pkg::BIT_LSB +: estx_pkg::BIT_W];
          d.addr = pwdata[estx_pkg::ADDR_LSB +: estx_pkg::DM_AW];
          case (d.op)
            estx_pkg::OP_SZ, estx_pkg::OP_SZA, estx_pkg::OP_SZB, estx_pkg::OP_XOR, estx_pkg::OP_XORM:
            begin
              d.dm_req.re = 1'b1;
              d.dm_req.addr = d.addr;
              d.st = estx_pkg::ST_RDWAIT;
            end
            estx_pkg::OP_TABRD, estx_pkg::OP_TABRDL, estx_pkg::OP_ITABRD, estx_pkg::OP_ITABRDL:
            begin
              d.st = estx_pkg::ST_TAB;
            end
            default:
            begin
              // Unknown codes retire as a single-cycle no-operation.
              d.pc = q.pc + estx_pkg::PC_STEP;
              d.done = 1'b1;
            end
          endcase
        end
      end
      estx_pkg::ST_RDWAIT:
      begin
        d.st = estx_pkg::ST_EXEC;
      end
      estx_pkg::ST_EXEC:
      begin
        if (ex.acc_ld)
        begin
          d.acc = ex.acc_val;
        end
        if (ex.z_wr)
        begin
          d.z = ex.z_val;
        end
        if (ex.mem_wr)
        begin
          d.dm_req.we = 1'b1;
          d.dm_req.addr = q.addr;
          d.dm_req.wdata = ex.mem_val;
        end
        d.skipped = ex.skip;
        if (ex.skip)
        begin
          d.pc = q.pc + estx_pkg::PC_SKIP_STEP;
          d.st = estx_pkg::ST_DUMMY;
        end
        else
        begin
          d.pc = q.pc + estx_pkg::PC_STEP;
          d.done = 1'b1;
          d.st = estx_pkg::ST_IDLE;
        end
      end
      estx_pkg::ST_TAB:
      begin
        d.pm_req.re = 1'b1;
        d.skipped = 1'b0;
        case (q.op)
          estx_pkg::OP_TABRD: d.pm_req.addr = {q.pc[estx_pkg::PM_AW-1 -: estx_pkg::PAGE_HI_W], q.tptr_lo};
          estx_pkg::OP_TABRDL: d.pm_req.addr = {estx_pkg::LAST_PAGE, q.tptr_lo};
          estx_pkg::OP_ITABRD:
          begin
            d.tptr_lo = tptr_lo_inc;
            d.pm_req.addr = {q.tptr_hi[estx_pkg::PAGE_HI_W-1:0], tptr_lo_inc};
          end
          default:
          begin
            d.tptr_lo = tptr_lo_inc;
            d.pm_req.addr = {estx_pkg::LAST_PAGE, tptr_lo_inc};
          end
        endcase
        d.st = estx_pkg::ST_PMWAIT;
      end
      estx_pkg::ST_PMWAIT:
      begin
        d.st = estx_pkg::ST_TABWB;
      end
      estx_pkg::ST_TABWB:
      begin
        d.tlatch = pm_rdata[estx_pkg::PM_DW-1 -: estx_pkg::DW];
        d.dm_req.we = 1'b1;
        d.dm_req.addr = q.addr;
        d.dm_req.wdata = pm_rdata[estx_pkg::DW-1:0];
        d.pc = q.pc + estx_pkg::PC_STEP;
        d.done = 1'b1;
        d.st = estx_pkg::ST_IDLE;
      end
      estx_pkg::ST_DUMMY:
      begin
        d.done = 1'b1;
        d.st = estx_pkg::ST_IDLE;
      end
      default:
      begin
        d.st = estx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '{st: estx_pkg::ST_IDLE, op: estx_pkg::OP_NOP, pc: estx_pkg::PC_RST, default: '0};
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sz_skip;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_EXEC && q.op == estx_pkg::OP_SZ)
    |=> (skip_dummy == ($past(dm_rdata) == estx_pkg::ZERO_BYTE)) && q.z == $past(q.z) && q.acc == $past(q.acc);
  endproperty
  a_sz_skip: assert property (p_sz_skip) else $error("byte skip decision or flags wrong");

  property p_dummy_len;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    $rose(skip_dummy) |-> q.pc == $past(q.pc) + estx_pkg::PC_SKIP_STEP ##1 (!skip_dummy && instr_done);
  endproperty
  a_dummy_len: assert property (p_dummy_len) else $error("skip dummy cycle not exactly one");

  property p_sza_move;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_EXEC && q.op == estx_pkg::OP_SZA)
    |=> q.acc == $past(dm_rdata) && q.z == $past(q.z) && skip_dummy == (q.acc == estx_pkg::ZERO_BYTE);
  endproperty
  a_sza_move: assert property (p_sza_move) else $error("move-and-skip result wrong");

  property p_bit_skip;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_EXEC && q.op == estx_pkg::OP_SZB)
    |=> skip_dummy == !$past(dm_rdata[q.bit_sel]) && q.z == $past(q.z);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip decision wrong");

  property p_tab_cur;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_TAB && q.op == estx_pkg::OP_TABRD)
    |=> pm_req.re && pm_req.addr == {$past(q.pc[estx_pkg::PM_AW-1 -: estx_pkg::PAGE_HI_W]), $past(q.tptr_lo)};
  endproperty
  a_tab_cur: assert property (p_tab_cur) else $error("current page table address wrong");

  property p_tab_wb;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_TABWB)
    |=> dm_req.we && dm_req.wdata == $past(pm_rdata[estx_pkg::DW-1:0])
        && q.tlatch == $past(pm_rdata[estx_pkg::PM_DW-1 -: estx_pkg::DW]);
  endproperty
  a_tab_wb: assert property (p_tab_wb) else $error("table word not split into memory and latch");

  property p_tab_last;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_TAB && q.op == estx_pkg::OP_TABRDL)
    |=> pm_req.addr == {estx_pkg::LAST_PAGE, $past(q.tptr_lo)} ##2 dm_req.we;
  endproperty
  a_tab_last: assert property (p_tab_last) else $error("last page table read wrong");

  property p_preinc;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_TAB && q.op == estx_pkg::OP_ITABRD)
    |=> q.tptr_lo == $past(q.tptr_lo) + estx_pkg::ONE_BYTE
        && pm_req.addr == {$past(q.tptr_hi[estx_pkg::PAGE_HI_W-1:0]), q.tptr_lo};
  endproperty
  a_preinc: assert property (p_preinc) else $error("pre-increment table read wrong");

  property p_preinc_last;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_TAB && q.op == estx_pkg::OP_ITABRDL)
    |=> pm_req.addr == {estx_pkg::LAST_PAGE, q.tptr_lo} && q.tptr_lo == $past(q.tptr_lo) + estx_pkg::ONE_BYTE
        ##2 q.z == $past(q.z, 3);
  endproperty
  a_preinc_last: assert property (p_preinc_last) else $error("pre-increment last page read wrong");

  property p_xor_acc;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_EXEC && q.op == estx_pkg::OP_XOR)
    |=> q.acc == ($past(q.acc) ^ $past(dm_rdata)) && q.z == (q.acc == estx_pkg::ZERO_BYTE) && !dm_req.we;
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor to accumulator wrong");

  property p_xor_mem;
    @(posedge sys_clk iff ce) disable iff (!rst_b)
    (q.st == estx_pkg::ST_EXEC && q.op == estx_pkg::OP_XORM)
    |=> dm_req.we && dm_req.wdata == ($past(q.acc) ^ $past(dm_rdata)) && q.acc == $past(q.acc)
        && q.z == (dm_req.wdata == estx_pkg::ZERO_BYTE);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

endmodule

/* File: estx_mem_model.sv */
// Behavioural program and data memories that face the extended-instruction executor.
// Assumes requests from estx_exec_top on sys_clk, with read data due in the cycle after re.
`timescale 1ns/1ps
module estx_mem_model (
  input wire logic sys_clk,
  input wire estx_pkg::estx_dm_req_t dm_req,
  output logic [estx_pkg::DW-1:0] dm_rdata,
  input wire estx_pkg::estx_pm_req_t pm_req,
  output logic [estx_pkg::PM_DW-1:0] pm_rdata
);
  logic [estx_pkg::DW-1:0] dm [0:(1 << estx_pkg::DM_AW)-1];
  logic [estx_pkg::PM_DW-1:0] pm [0:(1 << estx_pkg::PM_AW)-1];

  initial
  begin
    dm_rdata = 8'h00;
    pm_rdata = 16'h0000;
  end

  // Outside the one valid cycle the read buses invert every cycle, so a late sample cannot pass by luck.
  always @(posedge sys_clk)
  begin
    if (dm_req.we)
      dm[dm_req.addr] <= dm_req.wdata;
    dm_rdata <= dm_req.re ? dm[dm_req.addr] : ~dm_rdata;
    pm_rdata <= pm_req.re ? pm[pm_req.addr] : ~pm_rdata;
  end
endmodule

/* File: estx_tb.sv */
// Self-checking testbench for the extended skip, table-read and XOR executor.
// Assumes zero-wait APB slave answers and the memory model in estx_mem_model.
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic pslverr;
  logic skip_dummy;
  logic instr_done;
  logic [31:0] prdata;
  estx_pkg::estx_dm_req_t dm_req;
  estx_pkg::estx_pm_req_t pm_req;
  logic [estx_pkg::DW-1:0] dm_rdata;
  logic [estx_pkg::PM_DW-1:0] pm_rdata;
  int miscompares = 0;
  int checked = 0;
  logic [11:0] exp_pc = 12'h000;
  logic exp_z = 1'b0;
  logic [31:0] rd;
  logic err;

  always #2.5 sys_clk = ~sys_clk;

  estx_exec_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .dm_req(dm_req), .dm_rdata(dm_rdata), .pm_req(pm_req),
    .pm_rdata(pm_rdata), .skip_dummy(skip_dummy), .instr_done(instr_done));

  estx_mem_model mem (.sys_clk(sys_clk), .dm_req(dm_req), .dm_rdata(dm_rdata), .pm_req(pm_req),
    .pm_rdata(pm_rdata));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; read data and the error flag are taken at the edge that sees pready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    compare(what, exp, rd);
  endtask

  // Issues one instruction, times it from the accepting edge and checks pc and status after it.
  task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [8:0] a, input logic skip);
    int n;
    logic sd;
    logic [31:0] mask;
    n = 0;
    sd = 1'b0;
    mask = (op < 4'h8) ? 32'h7 : 32'h3;
    apb(1'b1, estx_pkg::REG_INSTR, {7'h0, a, 9'h0, b, op});
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
      sd |= (skip_dummy === 1'b1);
    end
    while (instr_done !== 1'b1 && n < 16);
    compare("cycles", ((op >= 4'h4 && op <= 4'h7) ? 3 : 2) + skip, n);
    compare("skip_dummy", {31'h0, skip}, {31'h0, sd});
    exp_pc = exp_pc + (skip ? 12'h002 : 12'h001);
    rd_chk("pc", estx_pkg::REG_PC, {20'h0, exp_pc});
    apb(1'b0, estx_pkg::REG_STATUS, 32'h0);
    compare("status", {29'h0, skip, 1'b0, exp_z} & mask, rd & mask);
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    #50us;
    miscompares++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 1; i < 7; i++)
      rd_chk("reset", 8'(i * 4), 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    compare("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, estx_pkg::REG_TLATCH, 32'h55);
    compare("ro_write", 32'h1, {31'h0, err});
    mem.dm[9'h020] = 8'h5a;
    apb(1'b1, estx_pkg::REG_ACC, 32'h5a);
    exp_z = 1'b1;
    run(estx_pkg::OP_XOR, 3'h0, 9'h020, 1'b0);
    rd_chk("acc", estx_pkg::REG_ACC, 32'h0);
    mem.dm[9'h021] = 8'h0f;
    apb(1'b1, estx_pkg::REG_ACC, 32'h3c);
    exp_z = 1'b0;
    run(estx_pkg::OP_XORM, 3'h0, 9'h021, 1'b0);
    compare("dm_xor", 32'h33, mem.dm[9'h021]);
    rd_chk("acc", estx_pkg::REG_ACC, 32'h3c);
    mem.dm[9'h010] = 8'h00;
    mem.dm[9'h011] = 8'h80;
    run(estx_pkg::OP_SZ, 3'h0, 9'h010, 1'b1);
    run(estx_pkg::OP_SZ, 3'h0, 9'h011, 1'b0);
    mem.dm[9'h012] = 8'h00;
    mem.dm[9'h013] = 8'h81;
    run(estx_pkg::OP_SZA, 3'h0, 9'h012, 1'b1);
    rd_chk("acc", estx_pkg::REG_ACC, 32'h0);
    run(estx_pkg::OP_SZA, 3'h0, 9'h013, 1'b0);
    rd_chk("acc", estx_pkg::REG_ACC, 32'h81);
    for (int i = 0; i < 8; i++)
    begin
      mem.dm[9'h040 + i] = ~(8'h01 << i);
      mem.dm[9'h048 + i] = 8'h01 << i;
      run(estx_pkg::OP_SZB, 3'(i), 9'h040 + 9'(i), 1'b1);
      run(estx_pkg::OP_SZB, 3'(i), 9'h048 + 9'(i), 1'b0);
    end
    apb(1'b1, estx_pkg::REG_PC, 32'h3a0);
    exp_pc = 12'h3a0;
    apb(1'b1, estx_pkg::REG_TPTR_LO, 32'h44);
    mem.pm[12'h344] = 16'hbeef;
    mem.pm[12'hf44] = 16'h1234;
    run(estx_pkg::OP_TABRD, 3'h0, 9'h030, 1'b0);
    rd_chk("tlatch", estx_pkg::REG_TLATCH, 32'hbe);
    compare("dm_tab", 32'hef, mem.dm[9'h030]);
    run(estx_pkg::OP_TABRDL, 3'h0, 9'h031, 1'b0);
    rd_chk("tlatch", estx_pkg::REG_TLATCH, 32'h12);
    compare("dm_tab", 32'h34, mem.dm[9'h031]);
    // Pointer low wraps from ff; a carry into the high byte would fetch the decoy at 300.
    apb(1'b1, estx_pkg::REG_TPTR_HI, 32'h2);
    apb(1'b1, estx_pkg::REG_TPTR_LO, 32'hff);
    mem.pm[12'h200] = 16'hcafe;
    mem.pm[12'h2ff] = 16'h0bad;
    mem.pm[12'h300] = 16'hdead;
    run(estx_pkg::OP_ITABRD, 3'h0, 9'h032, 1'b0);
    rd_chk("tlatch", estx_pkg::REG_TLATCH, 32'hca);
    compare("dm_tab", 32'hfe, mem.dm[9'h032]);
    rd_chk("tptr_lo", estx_pkg::REG_TPTR_LO, 32'h0);
    apb(1'b1, estx_pkg::REG_TPTR_LO, 32'h10);
    mem.pm[12'hf10] = 16'h0bad;
    mem.pm[12'hf11] = 16'h5a71;
    run(estx_pkg::OP_ITABRDL, 3'h0, 9'h033, 1'b0);
    rd_chk("tlatch", estx_pkg::REG_TLATCH, 32'h5a);
    compare("dm_tab", 32'h71, mem.dm[9'h033]);
    rd_chk("tptr_lo", estx_pkg::REG_TPTR_LO, 32'h11);
    // A register write that lands while a table read is still running must be refused.
    mem.pm[12'h311] = 16'h4321;
    apb(1'b1, estx_pkg::REG_INSTR, {7'h0, 9'h034, 12'h0, 4'(estx_pkg::OP_TABRD)});
    apb(1'b1, estx_pkg::REG_ACC, 32'h77);
    compare("busy_write", 32'h1, {31'h0, err});
    repeat (8) @(posedge sys_clk);
    rd_chk("acc", estx_pkg::REG_ACC, 32'h81);
    compare("dm_tab", 32'h21, mem.dm[9'h034]);
    give_verdict();
  end
endmodule
